// ### verilog/frc_regs.vh
`ifndef FRC_REGS_VH
`define FRC_REGS_VH

// register addresses
`define FRC_ADDR_W 16
`define FRC_ADDR_CTRL 16'h01b7
`define FRC_ADDR_MODE 16'h01b5
`define FRC_ADDR_SUSP 16'h01b3

// reset values
`define FRC_RST_CTRL 8'h01
`define FRC_RST_MODE 8'h80
`define FRC_RST_SUSP 8'h40

// flash_control_status bits
`define FRC_B_READY 0
`define FRC_B_CRE 1
`define FRC_B_LBE 2
`define FRC_B_STOP 3
`define FRC_B_PERR 6
`define FRC_B_EERR 7

// flash_mode_lock_reg bits
`define FRC_B_MSEL 1
`define FRC_B_LOCK0 5
`define FRC_B_LOCK1 6
`define FRC_B_FIXED1 7

// flash_suspend_reg bits
`define FRC_B_SEN 0
`define FRC_B_ESR 1
`define FRC_B_PSR 2
`define FRC_B_EACT 3
`define FRC_B_PACT 4
`define FRC_B_RPERM 6
`define FRC_B_LPR 7

// software command codes
`define FRC_CMD_READ_ARRAY 8'hff
`define FRC_CMD_READ_STATUS 8'h70
`define FRC_CMD_CLEAR 8'h50
`define FRC_CMD_PROGRAM 8'h40
`define FRC_CMD_ERASE 8'h20
`define FRC_CMD_ERASE_OK 8'hd0

// block number field of a flash address
`define FRC_BLK_MSB 15
`define FRC_BLK_LSB 12

// order of the sequenced bits in the unlock vector
`define FRC_U_CRE 0
`define FRC_U_LBE 1
`define FRC_U_MSEL 2
`define FRC_U_LOCK0 3
`define FRC_U_LOCK1 4
`define FRC_U_SEN 5
`define FRC_U_LPR 6
`define FRC_U_N 7
// value each sequenced bit is written to: 1 except the two locks
`define FRC_U_TARGET 7'h67

`endif

// ### verilog/frc_unlock.v
`timescale 1ns/1ps
// per bit: armed after a write of the opposite value, so the next write
// of the target value takes; an interrupt in between disarms
module frc_unlock #(
    parameter W = 7
) (
    input wire clk,
    input wire reset_n,
    input wire [W-1:0] wr_en,
    input wire [W-1:0] wbit,
    input wire [W-1:0] target,
    input wire irq_req,
    output wire [W-1:0] armed
);
    reg [W-1:0] arm;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    arm[i] <= 1'b0;
                end else if (wr_en[i]) begin
                    arm[i] <= (wbit[i] != target[i]);
                end else if (irq_req) begin
                    arm[i] <= 1'b0;
                end
            end
        end
    endgenerate
    assign armed = arm;
endmodule // frc_unlock

// ### verilog/frc_cmd_decode.v
`timescale 1ns/1ps
`include "frc_regs.vh"
module frc_cmd_decode #(
    parameter AW = 16
) (
    input wire clk,
    input wire reset_n,
    input wire enable,
    input wire fw_wr,
    input wire [AW-1:0] fw_addr,
    input wire [7:0] fw_data,
    output reg cmd_program,
    output reg cmd_erase,
    output reg cmd_clear,
    output reg cmd_read_array,
    output reg cmd_read_status,
    output reg [AW-1:0] cmd_addr,
    output reg [7:0] cmd_data
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_PROG2 = 3'b010;
    localparam [2:0] ST_ERASE2 = 3'b100;
    reg [2:0] state;
    reg [AW-1:0] first_addr;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            first_addr <= {AW{1'b0}};
            cmd_program <= 1'b0;
            cmd_erase <= 1'b0;
            cmd_clear <= 1'b0;
            cmd_read_array <= 1'b0;
            cmd_read_status <= 1'b0;
            cmd_addr <= {AW{1'b0}};
            cmd_data <= 8'h00;
        end else begin
            cmd_program <= 1'b0;
            cmd_erase <= 1'b0;
            cmd_clear <= 1'b0;
            cmd_read_array <= 1'b0;
            cmd_read_status <= 1'b0;
            if (!enable) begin
                state <= ST_IDLE;
            end else if (fw_wr) begin
                case (state)
                    ST_PROG2: begin
                        // a second cycle at another address drops the command
                        cmd_program <= (fw_addr == first_addr);
                        cmd_addr <= fw_addr;
                        cmd_data <= fw_data;
                        state <= ST_IDLE;
                    end
                    ST_ERASE2: begin
                        cmd_erase <= (fw_data == `FRC_CMD_ERASE_OK);
                        cmd_addr <= fw_addr;
                        state <= ST_IDLE;
                    end
                    default: begin
                        first_addr <= fw_addr;
                        if (fw_data == `FRC_CMD_PROGRAM) begin
                            state <= ST_PROG2;
                        end else if (fw_data == `FRC_CMD_ERASE) begin
                            state <= ST_ERASE2;
                        end else begin
                            state <= ST_IDLE;
                        end
                        cmd_clear <= (fw_data == `FRC_CMD_CLEAR);
                        cmd_read_array <= (fw_data == `FRC_CMD_READ_ARRAY);
                        cmd_read_status <= (fw_data == `FRC_CMD_READ_STATUS);
                    end
                endcase
            end
        end
    end
endmodule // frc_cmd_decode

// ### verilog/frc_ctrl.v
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "frc_regs.vh"
// Contract
// - ready flag low while program/erase or suspended
// - commands accepted only with rewrite mode enabled
// - low-block enable 0 ignores block 0/1
// - block 0 needs low-block enable, lock clear
// - block 1 needs low-block enable, lock clear
// - stop bit blocks access, resets, lowers power
// - stop without rewrite mode only sets bit
// - stop/wait without rewrite mode powers flash off
// - program error flag set on failed program
// - erase error flag set on failed erase
// - clear status command clears both error flags
// - mode select 1 means interrupt-driven suspend
// - suspend only while suspend enable is 1
// - erase suspend request by software or interrupt
// - program suspend request by software or interrupt
// - erase-active high from start through suspend
// - program-active high from start through suspend
// - read permission low during running erase
// - low-power read bit reduces read power
// - rewrite enable set by 0-then-1 sequence only
// - low-block enable by sequence, cleared with mode
// - clear status is one write of 50h
// - clearing rewrite mode clears mode select
// - erase suspend request writable only during erase
module frc_ctrl #(
    parameter AW = `FRC_ADDR_W
) (
    input wire clk,
    input wire reset_n,
    input wire [AW-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire fw_wr,
    input wire [AW-1:0] fw_addr,
    input wire [7:0] fw_data,
    input wire irq_req,
    input wire stop_wait_req,
    output reg eng_prog_start,
    output reg eng_erase_start,
    output reg [AW-1:0] eng_addr,
    output reg [7:0] eng_data,
    input wire eng_done,
    input wire eng_error,
    output wire eng_suspend,
    output wire eng_reset,
    output wire flash_low_power,
    output wire flash_access_enable,
    output wire flash_power_on,
    output wire low_power_read,
    output reg read_status_mode
);
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_PROG = 5'b00010;
    localparam [4:0] ST_ERASE = 5'b00100;
    localparam [4:0] ST_PSUSP = 5'b01000;
    localparam [4:0] ST_ESUSP = 5'b10000;

    reg [4:0] state;
    reg [4:0] next_state;
    reg cpu_rewrite_enable;
    reg low_block_rewrite_enable;
    reg flash_stop;
    reg program_error_flag;
    reg erase_error_flag;
    reg suspend_mode_select;
    reg block0_write_lock;
    reg block1_write_lock;
    reg suspend_enable;
    reg erase_suspend_request;
    reg program_suspend_request;
    reg low_power_read_enable;

    wire wr_ctrl;
    wire wr_mode;
    wire wr_susp;
    wire stop_eff;
    wire cmd_enable;
    wire cmd_program;
    wire cmd_erase;
    wire cmd_clear;
    wire cmd_read_array;
    wire cmd_read_status;
    wire [AW-1:0] cmd_addr;
    wire [7:0] cmd_data;
    wire [`FRC_BLK_MSB-`FRC_BLK_LSB:0] cmd_block;
    wire block_ok;
    wire start_prog;
    wire start_erase;
    wire erasing;
    wire programming;
    wire ready_busy_flag;
    wire erase_active_flag;
    wire program_active_flag;
    wire read_permission_flag;
    wire interrupt_suspend_mode;
    wire software_suspend_mode;
    wire [`FRC_U_N-1:0] seq_wr;
    wire [`FRC_U_N-1:0] seq_bit;
    wire [`FRC_U_N-1:0] armed;
    wire [7:0] rd_ctrl;
    wire [7:0] rd_mode;
    wire [7:0] rd_susp;

    assign wr_ctrl = reg_wr && (reg_addr == `FRC_ADDR_CTRL);
    assign wr_mode = reg_wr && (reg_addr == `FRC_ADDR_MODE);
    assign wr_susp = reg_wr && (reg_addr == `FRC_ADDR_SUSP);

    // stop only acts while rewrite mode is on
    assign stop_eff = flash_stop && cpu_rewrite_enable;
    assign cmd_enable = cpu_rewrite_enable && !stop_eff;

    assign interrupt_suspend_mode = suspend_mode_select;
    assign software_suspend_mode = !suspend_mode_select;

    assign erasing = (state == ST_ERASE);
    assign programming = (state == ST_PROG);
    assign ready_busy_flag = (state == ST_IDLE);
    assign erase_active_flag = erasing || (state == ST_ESUSP);
    assign program_active_flag = programming || (state == ST_PSUSP);
    assign read_permission_flag = !erasing;

    assign eng_suspend = (state == ST_ESUSP) || (state == ST_PSUSP);
    assign eng_reset = stop_eff;
    assign flash_low_power = stop_eff;
    assign flash_access_enable = !stop_eff;
    // automatic power-down only when rewrite mode is off
    assign flash_power_on = !(stop_wait_req && !cpu_rewrite_enable);
    assign low_power_read = low_power_read_enable;

    // blocks above 1 are always writable; 0 and 1 need the enable and a clear lock
    assign cmd_block = cmd_addr[`FRC_BLK_MSB:`FRC_BLK_LSB];
    assign block_ok = (cmd_block > 1) ||
        (low_block_rewrite_enable && (cmd_block == 0) && !block0_write_lock) ||
        (low_block_rewrite_enable && (cmd_block == 1) && !block1_write_lock);
    assign start_prog = cmd_program && block_ok && ready_busy_flag;
    assign start_erase = cmd_erase && block_ok && ready_busy_flag;

    assign seq_wr[`FRC_U_CRE] = wr_ctrl;
    assign seq_wr[`FRC_U_LBE] = wr_ctrl;
    assign seq_wr[`FRC_U_MSEL] = wr_mode;
    assign seq_wr[`FRC_U_LOCK0] = wr_mode;
    assign seq_wr[`FRC_U_LOCK1] = wr_mode;
    assign seq_wr[`FRC_U_SEN] = wr_susp;
    assign seq_wr[`FRC_U_LPR] = wr_susp;
    assign seq_bit[`FRC_U_CRE] = reg_wdata[`FRC_B_CRE];
    assign seq_bit[`FRC_U_LBE] = reg_wdata[`FRC_B_LBE];
    assign seq_bit[`FRC_U_MSEL] = reg_wdata[`FRC_B_MSEL];
    assign seq_bit[`FRC_U_LOCK0] = reg_wdata[`FRC_B_LOCK0];
    assign seq_bit[`FRC_U_LOCK1] = reg_wdata[`FRC_B_LOCK1];
    assign seq_bit[`FRC_U_SEN] = reg_wdata[`FRC_B_SEN];
    assign seq_bit[`FRC_U_LPR] = reg_wdata[`FRC_B_LPR];

    frc_unlock #(
        .W(`FRC_U_N)
    ) u_unlock (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(seq_wr),
        .wbit(seq_bit),
        .target(`FRC_U_TARGET),
        .irq_req(irq_req),
        .armed(armed)
    );

    frc_cmd_decode #(
        .AW(AW)
    ) u_decode (
        .clk(clk),
        .reset_n(reset_n),
        .enable(cmd_enable),
        .fw_wr(fw_wr),
        .fw_addr(fw_addr),
        .fw_data(fw_data),
        .cmd_program(cmd_program),
        .cmd_erase(cmd_erase),
        .cmd_clear(cmd_clear),
        .cmd_read_array(cmd_read_array),
        .cmd_read_status(cmd_read_status),
        .cmd_addr(cmd_addr),
        .cmd_data(cmd_data)
    );

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_prog) begin
                    next_state = ST_PROG;
                end else if (start_erase) begin
                    next_state = ST_ERASE;
                end
            end
            ST_PROG: begin
                if (eng_done) begin
                    next_state = ST_IDLE;
                end else if (program_suspend_request) begin
                    next_state = ST_PSUSP;
                end
            end
            ST_ERASE: begin
                if (eng_done) begin
                    next_state = ST_IDLE;
                end else if (erase_suspend_request) begin
                    next_state = ST_ESUSP;
                end
            end
            ST_PSUSP: begin
                if (!program_suspend_request) begin
                    next_state = ST_PROG;
                end
            end
            ST_ESUSP: begin
                if (!erase_suspend_request) begin
                    next_state = ST_ERASE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (stop_eff) begin
            next_state = ST_IDLE;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            eng_prog_start <= 1'b0;
            eng_erase_start <= 1'b0;
            eng_addr <= {AW{1'b0}};
            eng_data <= 8'h00;
            read_status_mode <= 1'b0;
        end else begin
            state <= next_state;
            eng_prog_start <= start_prog && !stop_eff;
            eng_erase_start <= start_erase && !stop_eff;
            if (start_prog || start_erase) begin
                eng_addr <= cmd_addr;
                eng_data <= cmd_data;
            end
            // interrupt-driven mode has no status read; it returns to array reads
            if (stop_eff || cmd_read_array) begin
                read_status_mode <= 1'b0;
            end else if (cmd_read_status && software_suspend_mode) begin
                read_status_mode <= 1'b1;
            end else if ((start_prog || start_erase)) begin
                read_status_mode <= software_suspend_mode;
            end
        end
    end

    // error flags: a failing completion wins over a clear in the same cycle
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            program_error_flag <= 1'b0;
            erase_error_flag <= 1'b0;
        end else begin
            if (programming && eng_done && eng_error) begin
                program_error_flag <= 1'b1;
            end else if (cmd_clear) begin
                program_error_flag <= 1'b0;
            end
            if (erasing && eng_done && eng_error) begin
                erase_error_flag <= 1'b1;
            end else if (cmd_clear) begin
                erase_error_flag <= 1'b0;
            end
        end
    end

    // flash_control_status and flash_mode_lock_reg writable bits
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_rewrite_enable <= 1'b0;
            low_block_rewrite_enable <= 1'b0;
            flash_stop <= 1'b0;
            suspend_mode_select <= 1'b0;
            block0_write_lock <= 1'b0;
            block1_write_lock <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                flash_stop <= reg_wdata[`FRC_B_STOP];
                if (!reg_wdata[`FRC_B_CRE]) begin
                    cpu_rewrite_enable <= 1'b0;
                end else if (armed[`FRC_U_CRE]) begin
                    cpu_rewrite_enable <= 1'b1;
                end
                if (!reg_wdata[`FRC_B_LBE]) begin
                    low_block_rewrite_enable <= 1'b0;
                end else if (armed[`FRC_U_LBE] && cpu_rewrite_enable) begin
                    low_block_rewrite_enable <= 1'b1;
                end
            end
            if (wr_mode) begin
                if (!reg_wdata[`FRC_B_MSEL]) begin
                    suspend_mode_select <= 1'b0;
                end else if (armed[`FRC_U_MSEL] && cpu_rewrite_enable) begin
                    suspend_mode_select <= 1'b1;
                end
                if (cpu_rewrite_enable) begin
                    if (reg_wdata[`FRC_B_LOCK0]) begin
                        block0_write_lock <= 1'b1;
                    end else if (armed[`FRC_U_LOCK0]) begin
                        block0_write_lock <= 1'b0;
                    end
                    if (reg_wdata[`FRC_B_LOCK1]) begin
                        block1_write_lock <= 1'b1;
                    end else if (armed[`FRC_U_LOCK1]) begin
                        block1_write_lock <= 1'b0;
                    end
                end
            end
            // leaving rewrite mode drops the dependent bits
            if (wr_ctrl && !reg_wdata[`FRC_B_CRE]) begin
                low_block_rewrite_enable <= 1'b0;
                suspend_mode_select <= 1'b0;
                block0_write_lock <= 1'b0;
                block1_write_lock <= 1'b0;
            end
        end
    end

    // flash_suspend_reg: requests exist only during their own operation
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            suspend_enable <= 1'b0;
            low_power_read_enable <= 1'b0;
            erase_suspend_request <= 1'b0;
            program_suspend_request <= 1'b0;
        end else begin
            if (wr_susp) begin
                if (!reg_wdata[`FRC_B_SEN]) begin
                    suspend_enable <= 1'b0;
                end else if (armed[`FRC_U_SEN]) begin
                    suspend_enable <= 1'b1;
                end
                if (!reg_wdata[`FRC_B_LPR]) begin
                    low_power_read_enable <= 1'b0;
                end else if (armed[`FRC_U_LPR]) begin
                    low_power_read_enable <= 1'b1;
                end
            end
            if (!suspend_enable || !erase_active_flag || stop_eff) begin
                erase_suspend_request <= 1'b0;
            end else if (interrupt_suspend_mode && irq_req && erasing) begin
                erase_suspend_request <= 1'b1;
            end else if (wr_susp) begin
                // software may only clear it in interrupt-driven mode
                erase_suspend_request <= reg_wdata[`FRC_B_ESR] &&
                    (software_suspend_mode || erase_suspend_request);
            end
            if (!suspend_enable || !program_active_flag || stop_eff) begin
                program_suspend_request <= 1'b0;
            end else if (interrupt_suspend_mode && irq_req && programming) begin
                program_suspend_request <= 1'b1;
            end else if (wr_susp) begin
                program_suspend_request <= reg_wdata[`FRC_B_PSR] &&
                    (software_suspend_mode || program_suspend_request);
            end
        end
    end

    assign rd_ctrl = {erase_error_flag, program_error_flag, 2'b00, flash_stop,
        low_block_rewrite_enable, cpu_rewrite_enable, ready_busy_flag};
    assign rd_mode = {1'b1, block1_write_lock, block0_write_lock, 3'b000,
        suspend_mode_select, 1'b0};
    assign rd_susp = {low_power_read_enable, read_permission_flag, 1'b0,
        program_active_flag, erase_active_flag, program_suspend_request,
        erase_suspend_request, suspend_enable};

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `FRC_ADDR_CTRL) begin
                reg_rdata <= rd_ctrl;
            end else if (reg_addr == `FRC_ADDR_MODE) begin
                reg_rdata <= rd_mode;
            end else if (reg_addr == `FRC_ADDR_SUSP) begin
                reg_rdata <= rd_susp;
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // frc_ctrl

// ### tb/frc_flash_model.sv
`timescale 1ns/1ps
// flash engine stand-in: runs LEN cycles, pauses while suspended
module frc_flash_model #(
    parameter LEN = 20
) (
    input wire clk,
    input wire reset_n,
    input wire start,
    input wire eng_suspend,
    input wire eng_reset,
    input wire fail,
    output reg eng_done,
    output reg eng_error
);
    reg [7:0] left;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            left <= 8'h00;
            eng_done <= 1'b0;
            eng_error <= 1'b0;
        end else begin
            eng_done <= 1'b0;
            // error line only means something beside done
            eng_error <= ~eng_error;
            if (eng_reset)
                left <= 8'h00;
            else if (start)
                left <= LEN;
            else if (left != 8'h00 && !eng_suspend) begin
                left <= left - 8'h01;
                if (left == 8'h01) begin
                    eng_done <= 1'b1;
                    eng_error <= fail;
                end
            end
        end
    end
endmodule // frc_flash_model

// ### tb/frc_ctrl_props.sv
`timescale 1ns/1ps
module frc_ctrl_props (
    input wire clk,
    input wire reset_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire fw_wr,
    input wire [7:0] fw_data,
    input wire stop_wait_req,
    input wire eng_prog_start,
    input wire eng_erase_start,
    input wire [7:0] eng_data,
    input wire eng_suspend,
    input wire eng_reset,
    input wire flash_low_power,
    input wire flash_access_enable,
    input wire flash_power_on,
    input wire low_power_read
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_held_stop;
        eng_reset [*2];
    endsequence
    AST_RDATA_SLOT: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data outside its slot");
    AST_STOP_OUTS: assert property (flash_low_power == eng_reset && flash_access_enable == !eng_reset)
        else $error("stop outputs disagree");
    AST_STOP_IDLE: assert property (s_held_stop |-> !eng_suspend && !eng_prog_start && !eng_erase_start)
        else $error("engine active while stopped");
    AST_STOP_CAUSE: assert property ($rose(eng_reset) |-> $past(reg_wr))
        else $error("stop without register write");
    AST_POWER_OFF: assert property (!flash_power_on |-> stop_wait_req)
        else $error("power off without stop or wait");
    AST_PROG_CMD: assert property (eng_prog_start |-> $past(fw_wr, 2) && eng_data == $past(fw_data, 2))
        else $error("program start without data cycle");
    AST_ERASE_CMD: assert property (eng_erase_start |-> $past(fw_wr, 2) && $past(fw_data, 2) == 8'hd0)
        else $error("erase start without confirm");
    AST_ONE_START: assert property (!(eng_prog_start && eng_erase_start))
        else $error("two starts at once");
    AST_LPR_WRITE: assert property ($changed(low_power_read) |-> $past(reg_wr))
        else $error("low power read moved by itself");
endmodule // frc_ctrl_props
bind frc_ctrl frc_ctrl_props u_props (.*);

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    reg clk, reset_n, reg_wr, reg_rd, fw_wr, irq_req, stop_wait_req, fail;
    reg [15:0] reg_addr, fw_addr;
    reg [7:0] reg_wdata, fw_data;
    wire [7:0] reg_rdata;
    wire ps, es, done, err, susp, erst, lowp, acc, pwr, lpr, rsm;
    wire [15:0] ea;
    integer bad_count, tests_run;
    frc_ctrl u_frc_ctrl (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .fw_wr, .fw_addr, .fw_data, .irq_req, .stop_wait_req, .eng_prog_start(ps),
        .eng_erase_start(es), .eng_addr(ea), .eng_data(), .eng_done(done), .eng_error(err),
        .eng_suspend(susp), .eng_reset(erst), .flash_low_power(lowp), .flash_access_enable(acc),
        .flash_power_on(pwr), .low_power_read(lpr), .read_status_mode(rsm));
    frc_flash_model u_frc_flash_model (.clk, .reset_n, .start(ps | es),
        .eng_suspend(susp), .eng_reset(erst), .fail, .eng_done(done), .eng_error(err));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task close_out;
        begin
            $display("checks %0d bad %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [15:0] a, input [7:0] d);
        begin
            @(posedge clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [15:0] a, input [7:0] exp);
        begin
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 chk(reg_rdata, exp);
        end
    endtask
    task fw(input [15:0] a, input [7:0] d);
        begin
            @(posedge clk);
            fw_wr <= 1'b1;
            fw_addr <= a;
            fw_data <= d;
            @(posedge clk);
            fw_wr <= 1'b0;
        end
    endtask
    task irq;
        begin
            @(posedge clk);
            irq_req <= 1'b1;
            @(posedge clk);
            irq_req <= 1'b0;
        end
    endtask
    task wait_done;
        integer i;
        begin
            i = 0;
            while (done !== 1'b1 && i < 300) begin
                @(posedge clk);
                i = i + 1;
            end
            chk({7'h00, done}, 8'h01);
            repeat (2) @(posedge clk);
        end
    endtask
    task t_unlock;
        begin
            rd(16'h01b5, 8'h80);
            rd(16'h01b3, 8'h40);
            rd(16'h0100, 8'h00);
            fw(16'h2000, 8'h40);
            fw(16'h2000, 8'h55);
            rd(16'h01b7, 8'h01);
            wr(16'h01b7, 8'h02);
            rd(16'h01b7, 8'h01);
            wr(16'h01b7, 8'h00);
            irq;
            wr(16'h01b7, 8'h02);
            rd(16'h01b7, 8'h01);
            wr(16'h01b7, 8'h00);
            wr(16'h01b7, 8'h02);
            rd(16'h01b7, 8'h03);
            $display("unlock test done");
        end
    endtask
    task t_program;
        begin
            fw(16'h0000, 8'h40);
            fw(16'h0000, 8'h12);
            rd(16'h01b7, 8'h03);
            wr(16'h01b7, 8'h06);
            rd(16'h01b7, 8'h07);
            fail <= 1'b1;
            fw(16'h0010, 8'h40);
            fw(16'h0010, 8'h5a);
            rd(16'h01b7, 8'h06);
            rd(16'h01b3, 8'h50);
            chk({7'h00, rsm}, 8'h01);
            wait_done;
            rd(16'h01b7, 8'h47);
            rd(16'h01b3, 8'h40);
            fw(16'h2000, 8'h50);
            repeat (2) @(posedge clk);
            rd(16'h01b7, 8'h07);
            $display("program test done");
        end
    endtask
    task t_suspend;
        begin
            wr(16'h01b3, 8'h42);
            rd(16'h01b3, 8'h40);
            wr(16'h01b3, 8'h41);
            rd(16'h01b3, 8'h41);
            fw(16'h3000, 8'h20);
            fw(16'h3000, 8'hd0);
            wr(16'h01b3, 8'h43);
            rd(16'h01b3, 8'h4b);
            chk({7'h00, susp}, 8'h01);
            chk(ea[15:8], 8'h30);
            rd(16'h01b7, 8'h06);
            wr(16'h01b3, 8'h41);
            rd(16'h01b3, 8'h09);
            wait_done;
            rd(16'h01b7, 8'h87);
            rd(16'h01b3, 8'h41);
            fw(16'h2000, 8'h50);
            wr(16'h01b5, 8'h80);
            wr(16'h01b5, 8'h82);
            rd(16'h01b5, 8'h82);
            fw(16'h2000, 8'h40);
            fw(16'h2000, 8'ha5);
            irq;
            rd(16'h01b3, 8'h55);
            wr(16'h01b3, 8'h41);
            wait_done;
            rd(16'h01b3, 8'h41);
            $display("suspend test done");
        end
    endtask
    task t_stop;
        begin
            wr(16'h01b7, 8'h0b);
            #1 chk({6'h00, acc, erst}, 8'h01);
            wr(16'h01b7, 8'h08);
            rd(16'h01b7, 8'h49);
            chk({7'h00, erst}, 8'h00);
            rd(16'h01b5, 8'h80);
            @(posedge clk) stop_wait_req <= 1'b1;
            @(posedge clk) stop_wait_req <= 1'b0;
            chk({7'h00, pwr}, 8'h00);
            wr(16'h01b3, 8'h00);
            wr(16'h01b3, 8'h80);
            #1 chk({7'h00, lpr}, 8'h01);
            $display("stop test done");
        end
    endtask
    initial begin
        {reset_n, reg_wr, reg_rd, fw_wr, irq_req, stop_wait_req, fail} = 7'h00;
        {reg_addr, fw_addr, reg_wdata, fw_data} = 48'h0;
        bad_count = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rd(16'h01b7, 8'h01);
        t_unlock;
        t_program;
        t_suspend;
        t_stop;
        close_out;
    end
endmodule // tb_top
